// file: design/csob_pkg.sv
// Package for the current-sense over-current blanking block
// Shared constants and carrier structs; no clock domain assumptions
package csob_pkg;
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned BLANK_W         = 4;
  localparam int unsigned FILT_W          = 4;
  localparam int unsigned TRIP_W          = 4;
  localparam int unsigned REF_W           = 2;
  localparam int unsigned CNT_W           = 5;
  localparam logic [CNT_W-1:0] CNT_RESET  = 5'h00;
  localparam logic [CNT_W-1:0] TARGET_8   = 5'h08;
  localparam logic [CNT_W-1:0] TARGET_16  = 5'h10;
  localparam logic [1:0] QUIET_LIMIT      = 2'h3;
  localparam int unsigned BLANK_STEP_NS   = 100;
  localparam int unsigned BLANK_STEP_CYC  = (BLANK_STEP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned FILT_STEP_NS    = 200;
  localparam int unsigned FILT_STEP_CYC   = (FILT_STEP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  typedef enum logic [1:0] {
    CSOB_CNT_NONE  = 2'b00,
    CSOB_CNT_EVERY = 2'b01,
    CSOB_CNT_8     = 2'b10,
    CSOB_CNT_16    = 2'b11
  } csob_count_e;

  typedef struct packed {
    logic [BLANK_W-1:0] blank_time;
    logic [FILT_W-1:0]  trip_filter_sel;
    logic [TRIP_W-1:0]  pos_trip_level;
    logic [TRIP_W-1:0]  neg_trip_level;
    logic [REF_W-1:0]   sense_amp_config;
    logic               cut_pulse_off;
    logic               report_off;
    logic               brake_en;
    logic               trip_hold_sel;
    csob_count_e        trip_count_sel;
  } csob_cfg_s;
endpackage : csob_pkg

// file: design/csob_phase_ctr.sv
// One phase's over-current event counter with quiet-cycle reset
// Assumes one clock; cycle marks the PWM cycle boundary
`timescale 1ns/1ps
`default_nettype none
module csob_phase_ctr
  import csob_pkg::*;
(
  input  wire logic             ref_clk,   // Clock
  input  wire logic             reset_n,   // Async reset
  input  wire logic             event_in,  // Filtered trip event pulse
  input  wire logic             cycle,     // PWM cycle boundary pulse
  input  wire logic             clear,     // Counter clear
  output logic [CNT_W-1:0]      count      // Event count
);
  import csob_pkg::*;

  logic [1:0] quiet;
  logic       seen;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= CNT_RESET;
    end else if (clear) begin
      count <= CNT_RESET;
    end else if (event_in && count != '1) begin
      count <= count + 5'h01;
    end else if (cycle && !seen && quiet == QUIET_LIMIT - 2'h1) begin
      count <= CNT_RESET;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      quiet <= 2'h0;
      seen  <= 1'b0;
    end else if (cycle) begin
      seen  <= event_in;
      quiet <= (seen || event_in) ? 2'h0 : ((quiet == QUIET_LIMIT) ? quiet : quiet + 2'h1);
    end else if (event_in) begin
      seen <= 1'b1;
    end
  end

  quiet_reset_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (cycle && !seen && !event_in && !clear && quiet == 2'h2) |=> count == CNT_RESET)
    else $error("counter not reset after quiet cycles");
endmodule : csob_phase_ctr
`default_nettype wire

// file: design/csob_top.sv
// Current-sense blanking, trip filtering, counting, fault and truncation
// Assumes gate commands and comparator outputs synchronous to ref_clk
//
// How it works
// - Blank sense inputs on each high-gate edge
// - Hold offset until blanking interval elapses
// - OR phase blanking; suppress truncation inside
// - Offset scale selects regulator fraction
// - Independent positive and negative trip levels
// - Deglitch trips before fault handler
// - Truncation bypasses filter; fault flags truncation
// - Truncate immediately when truncation allowed
// - Count modes: none, every, 8, 16
// - Per-phase event counter increments per event
// - Fault when any counter reaches target
// - Three quiet cycles reset the counter
// - Latched counting: clear after clean period
// - Latched every-event: clear after condition gone
// - Unlatched: clear anytime, re-sets if present
// - Status records fault regardless of latching
// - Force high gates low until cycle reset
// - Any phase trip truncates all phases
// - Alternate recirculation truncates low side
// - Reaction settings changeable while active
// - Setting disables reporting and truncation both
// - Brake action instead of truncation
`timescale 1ns/1ps
`default_nettype none
module csob_top
  import csob_pkg::*;
(
  input  wire logic                   ref_clk,          // 20 MHz clock
  input  wire logic                   reset_n,          // Async reset, active low
  input  wire csob_pkg::csob_cfg_s    cfg,              // Live configuration
  input  wire logic                   single_pwm_mode,  // Single-PWM mode
  input  wire logic                   alt_recirc,       // Alternate recirculation
  input  wire logic                   recirc_phase,     // High-side recirculation period
  input  wire logic [2:0]             high_gate_cmd,    // High-side gate commands in
  input  wire logic [2:0]             low_gate_cmd,     // Low-side gate commands in
  input  wire logic [2:0]             pos_trip_cmp,     // Positive comparator outputs
  input  wire logic [2:0]             neg_trip_cmp,     // Negative comparator outputs
  input  wire logic                   fault_clear,      // Fault clear pulse
  output logic [2:0]                  high_gate_out,    // High-side gate outputs
  output logic [2:0]                  low_gate_out,     // Low-side gate outputs
  output logic [2:0]                  sense_connect,    // Amp inputs connected
  output logic [2:0]                  hold_offset,      // Amp output held at offset
  output logic [REF_W-1:0]            offset_scale,     // Offset scale code
  output logic [TRIP_W-1:0]           pos_dac,          // Positive DAC code
  output logic [TRIP_W-1:0]           neg_dac,          // Negative DAC code
  output logic                        fault_out_n,      // Fault output, active low
  output logic                        trip_status,      // Sticky fault status
  output logic                        truncating        // Truncation in effect
);
  import csob_pkg::*;

  localparam int unsigned BSTEP_W = $clog2(BLANK_STEP_CYC + 1);
  localparam int unsigned FSTEP_W = $clog2(FILT_STEP_CYC + 1);

  logic [2:0]         gate_prev;
  logic [2:0]         gate_edge;
  logic [2:0]         gate_rise;
  logic               cycle;
  logic [BLANK_W+BSTEP_W-1:0] blank_cnt [3];
  logic [2:0]         blanking;
  logic               any_blank;
  logic [2:0]         raw_trip;
  logic [2:0]         trip_prev;
  logic [FILT_W+FSTEP_W-1:0] filt_cnt [3];
  logic [2:0]         filt_trip;
  logic [2:0]         trip_event;
  logic [CNT_W-1:0]   count [3];
  logic               count_clr;
  logic [CNT_W-1:0]   target;
  logic               count_hit;
  logic [2:0]         hit_now;
  logic               fault;
  logic               fault_in_cycle;
  logic               clean_period;
  logic               cut_now;
  logic               cut_latch;
  logic               react_off;
  logic               fault_set;

  assign gate_edge = high_gate_cmd ^ gate_prev;
  assign gate_rise = high_gate_cmd & ~gate_prev;
  assign cycle     = |gate_rise;
  assign any_blank = |blanking;
  assign raw_trip  = pos_trip_cmp | neg_trip_cmp;
  assign react_off = cfg.cut_pulse_off && cfg.report_off && !cfg.brake_en;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      gate_prev <= 3'h0;
      trip_prev <= 3'h0;
    end else begin
      gate_prev <= high_gate_cmd;
      trip_prev <= filt_trip;
    end
  end

  // Blanking timers, one per phase, restarted on each high-gate edge
  for (genvar p = 0; p < 3; p++) begin : g_phase
    always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
        blank_cnt[p] <= '0;
      end else if (gate_edge[p]) begin
        blank_cnt[p] <= (BLANK_W+BSTEP_W)'(cfg.blank_time * BLANK_STEP_CYC);
      end else if (blank_cnt[p] != '0) begin
        blank_cnt[p] <= blank_cnt[p] - 1'b1;
      end
    end
    assign blanking[p] = gate_edge[p] ? (cfg.blank_time != '0) : (blank_cnt[p] > 1);

    // Deglitch filter; bypassed while truncation is allowed
    always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
        filt_cnt[p]  <= '0;
        filt_trip[p] <= 1'b0;
      end else if (!cfg.cut_pulse_off) begin
        filt_cnt[p]  <= '0;
        filt_trip[p] <= raw_trip[p];
      end else if (!raw_trip[p]) begin
        filt_cnt[p]  <= '0;
        filt_trip[p] <= 1'b0;
      end else if (filt_cnt[p] >= (FILT_W+FSTEP_W)'(cfg.trip_filter_sel * FILT_STEP_CYC)) begin
        filt_trip[p] <= 1'b1;
      end else begin
        filt_cnt[p] <= filt_cnt[p] + 1'b1;
      end
    end
    assign trip_event[p] = filt_trip[p] & ~trip_prev[p];
    assign hit_now[p]    = trip_event[p] && (count[p] >= target - 5'h01);

    csob_phase_ctr u_ctr (
      .ref_clk  (ref_clk),
      .reset_n  (reset_n),
      .event_in (trip_event[p]),
      .cycle    (cycle),
      .clear    (count_clr),
      .count    (count[p])
    );
  end

  always_comb begin
    case (cfg.trip_count_sel)
      CSOB_CNT_EVERY: target = 5'h01;
      CSOB_CNT_8:     target = TARGET_8;
      CSOB_CNT_16:    target = TARGET_16;
      default:        target = '1;
    endcase
  end

  // Every-event follows the trip level; counting modes fire on the event reaching target
  assign count_hit = (cfg.trip_count_sel == CSOB_CNT_EVERY) ? (|filt_trip) :
                     ((cfg.trip_count_sel != CSOB_CNT_NONE) && (|hit_now));
  assign count_clr = fault_clear && !fault_set;

  // In truncation mode the fault simply reports a truncation
  assign fault_set = !react_off && !cfg.report_off &&
                     (cfg.cut_pulse_off ? count_hit : (cut_now && cfg.trip_count_sel != CSOB_CNT_NONE));

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      fault_in_cycle <= 1'b0;
      clean_period   <= 1'b0;
    end else if (cycle) begin
      clean_period   <= !fault_in_cycle && !(|filt_trip);
      fault_in_cycle <= |filt_trip;
    end else if (|filt_trip) begin
      fault_in_cycle <= 1'b1;
      clean_period   <= 1'b0;
    end
  end

  // Set wins over clear; latched clears wait for their release condition
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      fault <= 1'b0;
    end else if (fault_set) begin
      fault <= 1'b1;
    end else if (fault_clear) begin
      if (!cfg.trip_hold_sel) begin
        fault <= 1'b0;
      end else if (cfg.trip_count_sel == CSOB_CNT_EVERY) begin
        fault <= |raw_trip;
      end else begin
        fault <= !clean_period;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      trip_status <= 1'b0;
      fault_out_n <= 1'b1;
    end else begin
      trip_status <= trip_status || fault_set || fault;
      fault_out_n <= !(fault_set || (fault && !(fault_clear && !cfg.trip_hold_sel)));
    end
  end

  // Any phase trip outside the blank window cuts all phases
  assign cut_now = !cfg.cut_pulse_off && !any_blank && (|filt_trip);

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cut_latch <= 1'b0;
    end else if (cycle) begin
      cut_latch <= 1'b0;
    end else if (cut_now && !react_off) begin
      cut_latch <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      high_gate_out <= 3'h0;
      low_gate_out  <= 3'h0;
      truncating    <= 1'b0;
    end else begin
      truncating <= cut_latch && !cycle;
      if (cfg.brake_en && fault) begin
        high_gate_out <= 3'h0;
        low_gate_out  <= 3'h7;
      end else if (cut_latch && !cycle && single_pwm_mode && alt_recirc && recirc_phase) begin
        high_gate_out <= high_gate_cmd;
        low_gate_out  <= 3'h0;
      end else if (cut_latch && !cycle) begin
        high_gate_out <= 3'h0;
        low_gate_out  <= low_gate_cmd;
      end else begin
        high_gate_out <= high_gate_cmd;
        low_gate_out  <= low_gate_cmd;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sense_connect <= 3'h0;
      hold_offset   <= 3'h7;
      offset_scale  <= '0;
      pos_dac       <= '0;
      neg_dac       <= '0;
    end else begin
      sense_connect <= ~blanking;
      hold_offset   <= blanking;
      offset_scale  <= cfg.sense_amp_config;
      pos_dac       <= cfg.pos_trip_level;
      neg_dac       <= cfg.neg_trip_level;
    end
  end

  blank_edge_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (gate_edge[0] && cfg.blank_time != '0) |=> !sense_connect[0] && hold_offset[0])
    else $error("inputs not blanked after gate edge");
  blank_mask_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (any_blank && !cut_latch && !cycle) |=> !cut_latch)
    else $error("truncation inside blank window");
  cut_all_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (cut_latch && !cycle && !cfg.brake_en && !(single_pwm_mode && alt_recirc)) |=> high_gate_out == 3'h0)
    else $error("high gates not all cut");
  cut_immediate_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (cut_now && !react_off && !cycle) |=> cut_latch)
    else $error("truncation not immediate");
  cycle_resume_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    cycle |=> !cut_latch)
    else $error("truncation survived cycle reset");
  fault_target_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (count_hit && cfg.cut_pulse_off && !cfg.report_off) |=> !fault_out_n)
    else $error("fault not raised at target");
  status_sticky_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    trip_status |=> trip_status)
    else $error("status lost");
  unlatched_clear_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (fault_clear && !fault_set && !cfg.trip_hold_sel) |=> !fault)
    else $error("unlatched clear ignored");
  every_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (fault_clear && !fault_set && cfg.trip_hold_sel && cfg.trip_count_sel == CSOB_CNT_EVERY && |raw_trip)
      |=> fault)
    else $error("latched fault cleared while present");

  // Steps of the truncation and count walks
  sequence cut_start_s;
    cut_now && !react_off && !cycle;
  endsequence

  sequence cut_hold_s;
    cut_latch && !cycle && !cfg.brake_en && !(single_pwm_mode && alt_recirc);
  endsequence

  sequence recirc_hold_s;
    cut_latch && !cycle && !(cfg.brake_en && fault) && single_pwm_mode && alt_recirc && recirc_phase;
  endsequence

  sequence count_reach_s;
    cfg.cut_pulse_off && !cfg.report_off && (cfg.trip_count_sel == CSOB_CNT_8 || cfg.trip_count_sel == CSOB_CNT_16) && (|hit_now);
  endsequence

  cut_walk_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    cut_start_s ##1 cut_hold_s |=> (high_gate_out == 3'h0) && truncating)
    else $error("truncation walk incomplete");

  recirc_low_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    recirc_hold_s |=> (low_gate_out == 3'h0) && (high_gate_out == $past(high_gate_cmd)))
    else $error("recirculation cut not on low side");

  brake_gates_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (cfg.brake_en && fault) |=> (low_gate_out == 3'h7) && (high_gate_out == 3'h0))
    else $error("brake action missing");

  trunc_report_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (cut_now && !cfg.report_off && cfg.trip_count_sel != CSOB_CNT_NONE) |=> !fault_out_n)
    else $error("truncation not reported");

  filter_drop_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (cfg.cut_pulse_off && !raw_trip[0]) |=> !filt_trip[0])
    else $error("filter passed a dropped trip");

  count_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (fault_clear && fault && cfg.trip_hold_sel && !clean_period &&
     (cfg.trip_count_sel == CSOB_CNT_8 || cfg.trip_count_sel == CSOB_CNT_16)) |=> fault)
    else $error("latched count fault cleared early");

  react_off_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (react_off && !fault && !cut_latch) |=> !fault && !cut_latch)
    else $error("disabled protection reacted");

  count_fault_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    count_reach_s |=> fault && !fault_out_n)
    else $error("fault not raised on target event");

  blank_end_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (blank_cnt[0] == 1 && !gate_edge[0]) |=> sense_connect[0] && !hold_offset[0])
    else $error("inputs not reconnected after blanking");

  status_set_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    fault_set |=> trip_status)
    else $error("status missed a fault");
endmodule : csob_top
`default_nettype wire

// file: bench/csob_pwm_host.sv
// PWM source model of the host: one phase energised at a time, lows complementary
// Assumes callers enter pwm_cycle just after a falling edge of ref_clk
`timescale 1ns/1ps
`default_nettype none
module csob_pwm_host (
  input  wire logic  ref_clk,        // Clock
  output logic [2:0] high_gate_cmd,  // High-side commands
  output logic [2:0] low_gate_cmd    // Low-side commands
);
  initial begin
    high_gate_cmd = 3'h0;
    low_gate_cmd  = 3'h0;
  end

  // Block commutation only, so truncation stays a valid choice
  task automatic pwm_cycle(input logic [2:0] mask, input int hi, input int lo);
    high_gate_cmd = mask;
    low_gate_cmd  = ~mask;
    repeat (hi) @(negedge ref_clk);
    high_gate_cmd = 3'h0;
    @(negedge ref_clk);
    low_gate_cmd = 3'h7;
    repeat (lo) @(negedge ref_clk);
  endtask : pwm_cycle
endmodule : csob_pwm_host
`default_nettype wire

// file: bench/current_sense_ocp_blanking_bench.sv
// Self-checking bench for the current-sense blanking, trip and fault block
// Assumes the PWM host model and one 20 MHz clock; inputs change on falling edges
`timescale 1ns/1ps
`default_nettype none
module current_sense_ocp_blanking_bench;
  import csob_pkg::*;
  typedef struct {string n; logic [7:0] v;} csob_note_s;
  logic         ref_clk = 1'b0;
  logic         reset_n = 1'b0;
  csob_cfg_s    cfg;
  logic [2:0]   pos_trip_cmp = 3'h0;
  logic [2:0]   neg_trip_cmp = 3'h0;
  logic         single_pwm_mode = 1'b0;
  logic         alt_recirc = 1'b0;
  logic         recirc_phase = 1'b0;
  logic         fault_clear = 1'b0;
  logic [2:0]   hgc, lgc, hgo, lgo, sc, ho;
  logic [1:0]   oscale;
  logic [3:0]   pdac, ndac;
  logic         fault_n, stat, trunc;
  logic [31:0]  seed = 32'h658e9ceb;
  logic [31:0]  rnd;
  logic [7:0]   got;
  csob_note_s   q[$];
  csob_note_s   cur;
  int           fail_count = 0;
  int           samples_checked = 0;
  int           cycles = 0;

  csob_pwm_host host (.ref_clk(ref_clk), .high_gate_cmd(hgc), .low_gate_cmd(lgc));

  csob_top uut (.ref_clk(ref_clk), .reset_n(reset_n), .cfg(cfg), .single_pwm_mode(single_pwm_mode),
    .alt_recirc(alt_recirc), .recirc_phase(recirc_phase), .high_gate_cmd(hgc), .low_gate_cmd(lgc),
    .pos_trip_cmp(pos_trip_cmp), .neg_trip_cmp(neg_trip_cmp), .fault_clear(fault_clear),
    .high_gate_out(hgo), .low_gate_out(lgo), .sense_connect(sc), .hold_offset(ho),
    .offset_scale(oscale), .pos_dac(pdac), .neg_dac(ndac), .fault_out_n(fault_n),
    .trip_status(stat), .truncating(trunc));

  always #25 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 4000) begin
      fail_count++;
      test_done();
    end
  end

  function automatic logic [7:0] probe(input string n);
    case (n)
      "hgo":    probe = {5'h00, hgo};
      "lgo":    probe = {5'h00, lgo};
      "sc":     probe = {5'h00, sc};
      "ho":     probe = {5'h00, ho};
      "pdac":   probe = {4'h0, pdac};
      "ndac":   probe = {4'h0, ndac};
      "oscale": probe = {6'h00, oscale};
      "fault":  probe = {7'h00, fault_n};
      "stat":   probe = {7'h00, stat};
      default:  probe = {7'h00, trunc};
    endcase
  endfunction : probe

  // Results settle after each rising edge; oldest note first
  initial forever begin
    @(posedge ref_clk);
    #5;
    while (q.size() > 0) begin
      cur = q.pop_front();
      got = probe(cur.n);
      samples_checked++;
      if (got !== cur.v) begin
        fail_count++;
        $display("wrong value %s expected %h seen %h", cur.n, cur.v, got);
      end
    end
  end

  task automatic note(input string n, input logic [7:0] v);
    q.push_back('{n, v});
  endtask : note

  task automatic wt(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : wt

  task automatic clear_pulse;
    fault_clear = 1'b1;
    wt(1);
    fault_clear = 1'b0;
    wt(1);
  endtask : clear_pulse

  // One PWM period on phase 0 with an optional trip in its low part
  task automatic cyc(input logic trip);
    fork
      host.pwm_cycle(3'b001, 8, 20);
      begin
        wt(12);
        pos_trip_cmp[0] = trip;
        wt(8);
        pos_trip_cmp[0] = 1'b0;
      end
    join
  endtask : cyc

  task test_done;
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done

  initial begin
    cfg = '0;
    cfg.trip_count_sel = CSOB_CNT_EVERY;
    note("fault", 8'h01);
    note("ho", 8'h07);
    wt(3);
    reset_n = 1'b1;
    rnd = $random(seed);
    cfg.pos_trip_level = rnd[3:0];
    cfg.neg_trip_level = rnd[7:4];
    cfg.sense_amp_config = rnd[9:8];
    cfg.blank_time = 4'h3;
    wt(4);
    note("pdac", {4'h0, rnd[3:0]});
    note("ndac", {4'h0, rnd[7:4]});
    note("oscale", {6'h00, rnd[9:8]});
    note("stat", 8'h00);
    fork
      host.pwm_cycle(3'b010, 12, 10);
      begin
        note("sc", 8'h05);
        note("ho", 8'h02);
        wt(5);
        note("sc", 8'h05);
        wt(1);
        note("sc", 8'h07);
        wt(6);
        note("sc", 8'h05);
      end
    join
    // Long filter proves the truncation path skips it
    cfg.blank_time = 4'h1;
    cfg.trip_filter_sel = 4'hF;
    fork
      host.pwm_cycle(3'b001, 20, 10);
      begin
        wt(6);
        pos_trip_cmp[2] = 1'b1;
        wt(2);
        note("hgo", 8'h00);
        note("trunc", 8'h01);
        note("lgo", 8'h06);
        note("fault", 8'h00);
        note("stat", 8'h01);
        wt(2);
        pos_trip_cmp[2] = 1'b0;
      end
    join
    fork
      host.pwm_cycle(3'b001, 10, 5);
      begin
        pos_trip_cmp[2] = 1'b1;
        wt(1);
        pos_trip_cmp[2] = 1'b0;
        wt(2);
        note("trunc", 8'h00);
        note("hgo", 8'h01);
      end
    join
    // Alternate recirculation moves the cut to the low side
    single_pwm_mode = 1'b1;
    alt_recirc = 1'b1;
    recirc_phase = 1'b1;
    fork
      host.pwm_cycle(3'b001, 10, 5);
      begin
        wt(4);
        neg_trip_cmp[1] = 1'b1;
        wt(2);
        note("lgo", 8'h00);
        note("hgo", 8'h01);
        neg_trip_cmp[1] = 1'b0;
      end
    join
    single_pwm_mode = 1'b0;
    alt_recirc = 1'b0;
    recirc_phase = 1'b0;
    cfg.cut_pulse_off = 1'b1;
    clear_pulse();
    note("fault", 8'h01);
    cfg.trip_filter_sel = 4'h1;
    cfg.trip_hold_sel = 1'b1;
    cfg.trip_count_sel = CSOB_CNT_8;
    repeat (7) cyc(1'b1);
    repeat (4) cyc(1'b0);
    repeat (7) cyc(1'b1);
    note("fault", 8'h01);
    cyc(1'b1);
    note("fault", 8'h00);
    clear_pulse();
    note("fault", 8'h00);
    cyc(1'b0);
    cyc(1'b0);
    clear_pulse();
    note("fault", 8'h01);
    cfg.trip_count_sel = CSOB_CNT_EVERY;
    pos_trip_cmp[1] = 1'b1;
    wt(10);
    clear_pulse();
    note("fault", 8'h00);
    pos_trip_cmp[1] = 1'b0;
    wt(2);
    clear_pulse();
    note("fault", 8'h01);
    note("stat", 8'h01);
    cfg.brake_en = 1'b1;
    fork
      host.pwm_cycle(3'b100, 20, 5);
      begin
        wt(4);
        pos_trip_cmp[0] = 1'b1;
        wt(10);
        note("lgo", 8'h07);
        note("hgo", 8'h00);
        pos_trip_cmp[0] = 1'b0;
      end
    join
    clear_pulse();
    cfg.brake_en = 1'b0;
    cfg.report_off = 1'b1;
    cyc(1'b1);
    note("fault", 8'h01);
    wt(3);
    test_done();
  end
endmodule : current_sense_ocp_blanking_bench
`default_nettype wire
